// ### src/acp_dev.sv
/*
 * Coprocessor attachment: decodes the data and command ports and the
 * control word, stretches accesses on pause, limits the stretch, drives
 * interrupt line two.
 * Assumes the coprocessor core beside it on the cop_* ports and a host that
 * keeps its own ordering of bytes.
 */
`timescale 1ns/1ps
module acp_dev #(
    parameter int WAIT_LIMIT = acp_pkg::WAIT_LIMIT_CYC  // Longest stretch
) (
    input  wire logic       mclk,
    input  wire logic       sys_rst,
    acp_if.dev              bus,
    output logic            cop_wr,
    output logic            cop_wr_cmd,
    output logic [7:0]      cop_wdata,
    output logic            cop_rd,
    input  wire logic [7:0] cop_rdata,
    input  wire logic [7:0] cop_status,
    input  wire logic       cop_end,
    input  wire logic       cop_svreq,
    input  wire logic       cop_pause,
    output logic            cop_rst_n,
    input  wire logic       strap_end,
    input  wire logic       strap_svreq,
    input  wire logic       strap_pause,
    input  wire logic       pwr_fail
);
    import acp_pkg::*;

    localparam int CW = $clog2(WAIT_LIMIT + 1);

    ////////////////////////////////////////////////////////////////////////
    // Elaboration check
    if (WAIT_LIMIT < 1) begin : g_bad_limit
        $error("WAIT_LIMIT must be at least one cycle");
    end

    ////////////////////////////////////////////////////////////////////////
    // State
    typedef enum logic [1:0] {DS_IDLE, DS_WAIT, DS_REL} acp_dst_t;

    typedef struct packed {
        acp_dst_t        st;       // Access phase
        logic [CW-1:0]   wcnt;     // Stretch counter
        logic [7:0]      rdata;    // Byte to host
        logic            ack;      // End of access
        logic            ctrl_rst; // Control word reset bit
        logic            rst_n;    // Reset to coprocessor
        logic            cwr;      // Push/command pulse
        logic            ccmd;     // Pulse is a command
        logic [7:0]      wdata;    // Byte to coprocessor
        logic            crd;      // Pop pulse
        logic            done;     // Calculation complete
        logic            end_pend; // Unserviced end event
        logic            irq;      // Line two
    } acp_dev_state_t;

    acp_dev_state_t s;       // Registered state
    acp_dev_state_t next_s;  // Next state

    logic stall;  // Pause still honoured

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic
    always_comb
    begin
        next_s     = s;
        next_s.ack = 1'b0;
        next_s.cwr = 1'b0;
        next_s.crd = 1'b0;
        // Pause only counts with the strap fitted, and never past the limit
        stall = strap_pause && cop_pause && (s.wcnt < CW'(WAIT_LIMIT));  // see [RL10] [RL17]
        case (s.st)
            DS_IDLE:
            begin
                if (bus.io_wr || bus.io_rd)
                begin
                    // Two consecutive locations belong to the coprocessor
                    if (bus.io_addr == DATA_PORT_ADDR || bus.io_addr == CMD_PORT_ADDR)  // see [RL1]
                    begin
                        next_s.st   = DS_WAIT;
                        next_s.wcnt = '0;
                    end
                    else if (bus.io_addr == CTRL_WORD_ADDR && bus.io_wr)
                    begin
                        // Zero holds the coprocessor in reset
                        next_s.ctrl_rst = bus.io_wdata[RESET_BIT_POS];  // see [RL12]
                        next_s.ack      = 1'b1;
                        next_s.st       = DS_REL;
                    end
                end
            end
            DS_WAIT:
            begin
                if (stall)
                begin
                    // Keep stretching the host access
                    next_s.wcnt = s.wcnt + 1'b1;  // see [RL17]
                end
                else
                begin
                    next_s.ack = 1'b1;
                    next_s.st  = DS_REL;
                    if (bus.io_wr)
                    begin
                        // Bytes pass in host order, lowest first
                        next_s.cwr   = 1'b1;  // see [RL4]
                        next_s.ccmd  = (bus.io_addr == CMD_PORT_ADDR);
                        next_s.wdata = bus.io_wdata;
                        if (bus.io_addr == CMD_PORT_ADDR)
                        begin
                            // New command hides the old completion
                            next_s.done = 1'b0;  // see [RL18]
                        end
                    end
                    else if (bus.io_addr == DATA_PORT_ADDR)
                    begin
                        // Result pops highest byte first; a timed-out read is invalid
                        next_s.rdata = cop_rdata;  // see [RL6] [RL11]
                        next_s.crd   = 1'b1;
                    end
                    else
                    begin
                        // Status with busy forced while not complete
                        next_s.rdata = cop_status;  // see [RL7]
                        next_s.rdata[STATUS_BUSY_POS] = cop_status[STATUS_BUSY_POS] | ~s.done;
                        next_s.end_pend = 1'b0;
                    end
                end
            end
            DS_REL:
            begin
                // Wait for the host to drop its strobe
                if (!bus.io_wr && !bus.io_rd)
                begin
                    next_s.st = DS_IDLE;
                end
            end
            default:
            begin
                next_s.st = DS_IDLE;
            end
        endcase
        // Completion sets win over clears in the same cycle
        if (cop_end)
        begin
            next_s.done     = 1'b1;  // see [RL18]
            next_s.end_pend = 1'b1;
        end
        // Reset output follows the control bit; power-up forces it too
        next_s.rst_n = s.ctrl_rst;  // see [RL12] [RL14]
        // Trigger two is shared by end, service request and power fail
        next_s.irq = (strap_end && s.end_pend)   // see [RL8]
                   || (strap_svreq && cop_svreq) // see [RL9]
                   || pwr_fail;                  // see [RL16]
    end

    ////////////////////////////////////////////////////////////////////////
    // State register; power-up reset reaches the coprocessor
    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            s <= '{st: DS_IDLE, wcnt: '0, rdata: 8'h00, ack: 1'b0, ctrl_rst: 1'b1,
                   rst_n: 1'b0, cwr: 1'b0, ccmd: 1'b0, wdata: 8'h00, crd: 1'b0,
                   done: 1'b1, end_pend: 1'b0, irq: 1'b0};  // see [RL14]
        end
        else
        begin
            s <= next_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs straight from the state register
    assign bus.io_rdata     = s.rdata;
    assign bus.io_ack       = s.ack;
    assign bus.irq_line_two = s.irq;
    assign cop_wr           = s.cwr;
    assign cop_wr_cmd       = s.ccmd;
    assign cop_wdata        = s.wdata;
    assign cop_rd           = s.crd;
    assign cop_rst_n        = s.rst_n;

endmodule : acp_dev

// ### src/acp_host.sv
/*
 * Host controller: AHB-Lite slave registers that software uses to push
 * operands, issue commands, pop results, read status and pulse reset.
 * Assumes the attachment on the other side of acp_if and one AHB master.
 */
// Summary of operation
// [RL1] Two consecutive ports: data, then command/status
// [RL2] Operands pushed through the data port
// [RL3] Command write starts the calculation
// [RL4] Multi-byte operands go lowest byte first
// [RL5] Every byte transferred, none omitted
// [RL6] Results popped highest byte first
// [RL7] Command port read returns status
// [RL8] End output may drive line two
// [RL9] Service request may drive line two
// [RL10] Pause strap stretches host accesses
// [RL11] Never read result before completion
// [RL12] Zero in control bit three resets
// [RL13] Hold reset low at least 50 us
// [RL14] Power-up also resets the coprocessor
// [RL15] Keep other control bits from shadow
// [RL16] Line two shared with power fail
// [RL17] Wait stretch limited to 15.5 us
// [RL18] New command clears completion until done
`timescale 1ns/1ps
module acp_host #(
    parameter int RST_CYC = acp_pkg::RESET_LOW_CYC  // Reset low hold
) (
    input  wire logic        mclk,
    input  wire logic        sys_rst,
    acp_if.host              bus,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    output logic             irq
);
    import acp_pkg::*;

    localparam int CW = $clog2(RST_CYC + 1);

    ////////////////////////////////////////////////////////////////////////
    // Elaboration check
    if (RST_CYC < 2) begin : g_bad_rst
        $error("RST_CYC must be at least two cycles");
    end

    ////////////////////////////////////////////////////////////////////////
    // State
    typedef enum logic [1:0] {HS_IDLE, HS_ACC, HS_RDLY} acp_hst_t;
    typedef enum logic [1:0] {PH_NORM, PH_RLOW, PH_RHIGH} acp_hph_t;

    typedef struct packed {
        acp_hst_t        st;        // Engine phase
        acp_hph_t        ph;        // Normal access or reset step
        logic [CW-1:0]   cnt;       // Reset hold counter
        logic [7:0]      addr;      // I/O address
        logic [7:0]      wdata;     // I/O write byte
        logic            wr;        // I/O write strobe
        logic            rd;        // I/O read strobe
        logic [7:0]      result;    // Last byte read
        logic [7:0]      shadow;    // Control word copy
        logic [IRQ_W-1:0] irq_stat; // Sticky events
        logic [IRQ_W-1:0] irq_mask; // Event mask
        logic            irq;       // Interrupt output
        logic            dp_wr;     // Write data phase pending
        logic [7:0]      dp_addr;   // Its offset
        logic [31:0]     hrdata;    // Read data
    } acp_host_state_t;

    acp_host_state_t s;       // Registered state
    acp_host_state_t next_s;  // Next state

    logic [IRQ_W-1:0] irq_set;  // Events this cycle
    logic             aphase;   // AHB address phase taken

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic
    always_comb
    begin
        next_s  = s;
        irq_set = '0;
        aphase  = hsel && hready && htrans[1];
        // Address phase: latch writes, answer reads at once
        next_s.dp_wr = aphase && hwrite;
        if (aphase)
        begin
            next_s.dp_addr = haddr[7:0];
            if (!hwrite)
            begin
                if (haddr[7:0] == REG_RESULT)
                begin
                    next_s.hrdata = 32'h0000_0000;
                    next_s.hrdata[7:0] = s.result;
                    next_s.hrdata[RESULT_BUSY_POS] = (s.st != HS_IDLE);
                end
                else if (haddr[7:0] == REG_SHADOW)
                begin
                    next_s.hrdata = {24'h00_0000, s.shadow};
                end
                else if (haddr[7:0] == REG_IRQ_STAT)
                begin
                    next_s.hrdata   = {{(32-IRQ_W){1'b0}}, s.irq_stat};
                    next_s.irq_stat = '0;  // Read clears
                end
                else if (haddr[7:0] == REG_IRQ_MASK)
                begin
                    next_s.hrdata = {{(32-IRQ_W){1'b0}}, s.irq_mask};
                end
                else
                begin
                    next_s.hrdata = 32'h0000_0000;  // Unmapped reads zero
                end
            end
        end
        // Data phase of a write; I/O orders are dropped while busy
        if (s.dp_wr)
        begin
            if (s.dp_addr == REG_IRQ_MASK)
            begin
                next_s.irq_mask = hwdata[IRQ_W-1:0];
            end
            else if (s.st == HS_IDLE)
            begin
                next_s.ph    = PH_NORM;
                next_s.wdata = hwdata[7:0];
                if (s.dp_addr == REG_PUSH)
                begin
                    // Software pushes each operand byte, lowest first
                    next_s.addr = DATA_PORT_ADDR;  // see [RL2] [RL4] [RL5]
                    next_s.wr   = 1'b1;
                    next_s.st   = HS_ACC;
                end
                else if (s.dp_addr == REG_CMD)
                begin
                    // Command write starts the calculation
                    next_s.addr = CMD_PORT_ADDR;  // see [RL1] [RL3]
                    next_s.wr   = 1'b1;
                    next_s.st   = HS_ACC;
                end
                else if (s.dp_addr == REG_POP)
                begin
                    // Software pops only after status shows completion
                    next_s.addr = DATA_PORT_ADDR;  // see [RL6] [RL11]
                    next_s.rd   = 1'b1;
                    next_s.st   = HS_ACC;
                end
                else if (s.dp_addr == REG_STAT)
                begin
                    next_s.addr = CMD_PORT_ADDR;  // see [RL7]
                    next_s.rd   = 1'b1;
                    next_s.st   = HS_ACC;
                end
                else if (s.dp_addr == REG_SHADOW)
                begin
                    // Control word is write-only; keep our copy of it
                    next_s.shadow = hwdata[7:0];  // see [RL15]
                    next_s.addr   = CTRL_WORD_ADDR;
                    next_s.wr     = 1'b1;
                    next_s.st     = HS_ACC;
                end
                else if (s.dp_addr == REG_RESET)
                begin
                    // Other bits come from the shadow, reset bit low
                    next_s.addr  = CTRL_WORD_ADDR;  // see [RL12] [RL15]
                    next_s.wdata = s.shadow;
                    next_s.wdata[RESET_BIT_POS] = 1'b0;
                    next_s.wr    = 1'b1;
                    next_s.ph    = PH_RLOW;
                    next_s.st    = HS_ACC;
                end
            end
        end
        // I/O engine
        case (s.st)
            HS_IDLE:
            begin
                // Orders start from the write data phase above; keep its phase
            end
            HS_ACC:
            begin
                if (bus.io_ack)
                begin
                    next_s.wr = 1'b0;
                    next_s.rd = 1'b0;
                    if (s.rd)
                    begin
                        next_s.result = bus.io_rdata;
                    end
                    if (s.ph == PH_RLOW)
                    begin
                        next_s.cnt = '0;
                        next_s.st  = HS_RDLY;
                    end
                    else if (s.ph == PH_RHIGH)
                    begin
                        irq_set[IRQ_RST_POS] = 1'b1;
                        next_s.st = HS_IDLE;
                    end
                    else
                    begin
                        irq_set[IRQ_DONE_POS] = 1'b1;
                        next_s.st = HS_IDLE;
                    end
                end
            end
            HS_RDLY:
            begin
                // Hold reset low for the least time, then release
                next_s.cnt = s.cnt + 1'b1;  // see [RL13]
                if (s.cnt == CW'(RST_CYC - 1))
                begin
                    next_s.wdata = s.shadow;
                    next_s.wdata[RESET_BIT_POS] = 1'b1;
                    next_s.wr = 1'b1;
                    next_s.ph = PH_RHIGH;
                    next_s.st = HS_ACC;
                end
            end
            default:
            begin
                next_s.st = HS_IDLE;
            end
        endcase
        // Line two is a level; events set after the read clear
        irq_set[IRQ_COP_POS] = bus.irq_line_two;  // see [RL16]
        next_s.irq_stat = next_s.irq_stat | irq_set;
        next_s.irq = |(s.irq_stat & s.irq_mask);
    end

    ////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            s <= '{st: HS_IDLE, ph: PH_NORM, cnt: '0, addr: 8'h00, wdata: 8'h00,
                   wr: 1'b0, rd: 1'b0, result: 8'h00, shadow: CTRL_WORD_RESET,
                   irq_stat: '0, irq_mask: '0, irq: 1'b0, dp_wr: 1'b0,
                   dp_addr: 8'h00, hrdata: 32'h0000_0000};
        end
        else
        begin
            s <= next_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs; the slave never stalls and always answers OKAY
    assign bus.io_addr  = s.addr;
    assign bus.io_wdata = s.wdata;
    assign bus.io_wr    = s.wr;
    assign bus.io_rd    = s.rd;
    assign hrdata       = s.hrdata;
    assign hreadyout    = 1'b1;
    assign hresp        = 1'b0;
    assign irq          = s.irq;

endmodule : acp_host

// ### src/acp_if.sv
/*
 * Host I/O bus between controller and coprocessor attachment.
 * Assumes both ends share mclk; strobes are levels held until io_ack.
 */
`timescale 1ns/1ps
interface acp_if;
    logic [7:0] io_addr;       // I/O address
    logic [7:0] io_wdata;      // Write byte
    logic       io_wr;         // Write strobe, held until ack
    logic       io_rd;         // Read strobe, held until ack
    logic [7:0] io_rdata;      // Read byte, valid with ack
    logic       io_ack;        // One-cycle end of access
    logic       irq_line_two;  // Trigger input 2 of interrupt/timer unit

    modport host (output io_addr, output io_wdata, output io_wr, output io_rd,
                  input io_rdata, input io_ack, input irq_line_two);
    modport dev  (input io_addr, input io_wdata, input io_wr, input io_rd,
                  output io_rdata, output io_ack, output irq_line_two);
endinterface : acp_if

// ### src/acp_pkg.sv
/*
 * Shared constants of the arithmetic coprocessor port: I/O locations,
 * control word layout, timing counts and the controller's register map.
 * Assumes a single 25 MHz system clock for both ends.
 */
package acp_pkg;

    // I/O locations decoded by the attachment
    localparam logic [7:0] DATA_PORT_ADDR  = 8'h10;  // Operand push / result pop
    localparam logic [7:0] CMD_PORT_ADDR   = 8'h11;  // Command write / status read
    localparam logic [7:0] CTRL_WORD_ADDR  = 8'hA0;  // System control word
    localparam int         RESET_BIT_POS   = 3;      // Active-low coprocessor reset
    localparam logic [7:0] CTRL_WORD_RESET = 8'hFF;  // Shadow value after reset
    localparam int         STATUS_BUSY_POS = 7;      // Busy flag in status byte

    // Timing: figures in ns, counts derived at 25 MHz
    localparam int CLK_MHZ        = 25;
    localparam int RESET_LOW_NS   = 50000;                              // Least time
    localparam int RESET_LOW_CYC  = (RESET_LOW_NS * CLK_MHZ + 999) / 1000;
    localparam int WAIT_LIMIT_NS  = 15500;                              // Longest time
    localparam int WAIT_LIMIT_CYC = (WAIT_LIMIT_NS * CLK_MHZ) / 1000;

    // Controller register offsets on AHB-Lite
    localparam logic [7:0] REG_PUSH     = 8'h00;  // W: push operand byte
    localparam logic [7:0] REG_CMD      = 8'h04;  // W: issue command byte
    localparam logic [7:0] REG_POP      = 8'h08;  // W: pop one result byte
    localparam logic [7:0] REG_STAT     = 8'h0C;  // W: fetch status byte
    localparam logic [7:0] REG_RESULT   = 8'h10;  // R: last byte read, busy
    localparam logic [7:0] REG_SHADOW   = 8'h14;  // RW: control word copy
    localparam logic [7:0] REG_IRQ_STAT = 8'h18;  // R: sticky events, read clears
    localparam logic [7:0] REG_IRQ_MASK = 8'h1C;  // RW: event mask
    localparam logic [7:0] REG_RESET    = 8'h20;  // W: pulse coprocessor reset

    // Interrupt status layout
    localparam int IRQ_W        = 3;
    localparam int IRQ_DONE_POS = 0;  // An I/O access finished
    localparam int IRQ_COP_POS  = 1;  // Coprocessor interrupt line seen
    localparam int IRQ_RST_POS  = 2;  // Reset pulse finished
    localparam int RESULT_BUSY_POS = 8;

endpackage : acp_pkg

// ### test/acp_chk.sv
/* Checker for the host I/O link between controller and attachment.
   Assumes the acp_if signals, mclk and sys_rst wired in as plain inputs. */
`timescale 1ns/1ps
module acp_chk
(
    input wire logic       mclk,
    input wire logic       sys_rst,
    input wire logic [7:0] io_addr,
    input wire logic [7:0] io_wdata,
    input wire logic       io_wr,
    input wire logic       io_rd,
    input wire logic [7:0] io_rdata,
    input wire logic       io_ack,
    input wire logic       irq_line_two
);
    import acp_pkg::*;
    logic io_req;  // Any access in flight
    assign io_req = io_wr | io_rd;
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (sys_rst);
    ////////////////////////////////////////////////////////////////////////////
    a_ack_pulse: assert property (io_ack |=> !io_ack)
        else $error("ack longer than one cycle");
    a_ack_strobe: assert property (io_ack |-> io_req)
        else $error("ack without strobe");
    a_ack_bound: assert property ($rose(io_req) |-> ##[1:12] io_ack)
        else $error("stretch not limited");
    a_req_held: assert property (io_req && !io_ack |=> io_req && $stable(io_addr)
        && $stable(io_wdata)) else $error("access dropped early");
    a_drop_after: assert property (io_ack |=> !io_req)
        else $error("strobe kept after ack");
    a_one_dir: assert property (!(io_wr && io_rd))
        else $error("read and write together");
    a_legal_addr: assert property (io_req |-> io_addr == DATA_PORT_ADDR
        || io_addr == CMD_PORT_ADDR || (io_wr && io_addr == CTRL_WORD_ADDR))
        else $error("bad I/O address");
    a_no_fast_ack: assert property ($rose(io_req) && io_addr != CTRL_WORD_ADDR
        |=> !io_ack) else $error("ack too soon");
    a_rdata_held: assert property (io_ack && io_rd |=> $stable(io_rdata))
        else $error("read byte not held");
endmodule : acp_chk

// ### test/tb.sv
/* Bench: controller and attachment joined by acp_if, with a coprocessor
   model on the cop_* side. Assumes acp_pkg register offsets. */
`timescale 1ns/1ps
`define CHK(a,b) begin checks_done++; if ((a) !== (b)) begin mismatches++; \
 $display("wrong value at %0t: %h vs %h", $time, a, b); end end
module tb;
    import acp_pkg::*;
    logic        mclk = 0, sys_rst = 1, hsel = 0, hwrite = 0, strap = 1;
    logic        hreadyout, irq, cop_wr, cop_wr_cmd, cop_rd, cop_rst_n;
    logic        cop_end = 0, cop_pause = 0, svreq = 0, pwr = 0, hresp;
    logic [1:0]  htrans = 0;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, rd, opnd, rv;
    logic [7:0]  cop_wdata, top = 0, cop_status = 0, cmd, sh;
    logic [7:0]  got[$], res[$];  // Pushed bytes, pending result bytes
    int          mismatches = 0, checks_done = 0, cyc = 0, cnt = 0, n;
    int          seed = 32'h4B5623EE;
    acp_if bus();
    acp_host #(.RST_CYC(8)) i_acp_host(.mclk(mclk), .sys_rst(sys_rst), .bus(bus),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .irq(irq));
    acp_dev #(.WAIT_LIMIT(4)) i_acp_dev(.mclk(mclk), .sys_rst(sys_rst), .bus(bus),
        .cop_wr(cop_wr), .cop_wr_cmd(cop_wr_cmd), .cop_wdata(cop_wdata), .cop_rd(cop_rd),
        .cop_rdata(top), .cop_status(cop_status), .cop_end(cop_end), .cop_svreq(svreq),
        .cop_pause(cop_pause), .cop_rst_n(cop_rst_n), .strap_end(strap),
        .strap_svreq(strap), .strap_pause(strap), .pwr_fail(pwr));
    acp_chk i_acp_chk(.mclk(mclk), .sys_rst(sys_rst), .io_addr(bus.io_addr),
        .io_wdata(bus.io_wdata), .io_wr(bus.io_wr), .io_rd(bus.io_rd),
        .io_rdata(bus.io_rdata), .io_ack(bus.io_ack), .irq_line_two(bus.irq_line_two));
    always #20 mclk = ~mclk;
    ////////////////////////////////////////////////////////////////////////////
    // Coprocessor model: stack of bytes, sum result, MSB first out; timeout
    always @(posedge mclk)
    begin
        if (cop_wr && !cop_wr_cmd) got.push_back(cop_wdata);
        if (cop_wr && cop_wr_cmd) rv = {got[3], got[2], got[1], got[0]} + cop_wdata;
        if (cop_wr && cop_wr_cmd) cnt = 40;  // Slow on purpose: status seen busy
        if (cop_rd && res.size() > 0) void'(res.pop_front());
        if (cnt == 1) for (int i = 3; i >= 0; i--) res.push_back(8'(rv >> (8 * i)));
        cop_end <= (cnt == 1);
        if (cnt > 0) cnt--;
        top <= (res.size() > 0) ? res[0] : 8'hC3;  // Junk when empty
        cyc++;
        if (cyc == 20000) begin mismatches++; close_out(); end
    end
    ////////////////////////////////////////////////////////////////////////////
    // One AHB-Lite single transfer; read data left in rd
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        hsel <= 1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : ahb
    // Order an I/O access, then poll busy; rd ends holding RESULT
    task automatic io(input logic [7:0] a, input logic [31:0] d);
        ahb(1, a, d);
        repeat (2) @(posedge mclk);
        for (int k = 0; k < 40; k++)
        begin
            ahb(0, REG_RESULT, 0);
            if (rd[8] === 1'b0) break;
        end
    endtask : io
    task close_out;
        $display("mismatches %0d checks %0d", mismatches, checks_done);
        if (mismatches == 0 && checks_done > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : close_out
    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (16) @(posedge mclk);
        `CHK(cop_rst_n, 1'b0)
        sys_rst <= 0;
        opnd = $random(seed);
        cmd = $random(seed);
        cop_status <= 8'($random(seed)) & 8'h7F;
        ahb(1, REG_IRQ_MASK, 0);
        for (int i = 0; i < 4; i++) io(REG_PUSH, opnd >> (8 * i));
        `CHK(irq, 1'b0)
        for (int i = 0; i < 4; i++) `CHK(got[i], opnd[8*i +: 8])
        ahb(1, REG_IRQ_MASK, 32'h3);
        io(REG_CMD, cmd);
        `CHK(irq, 1'b1)
        ahb(0, REG_IRQ_STAT, 0);
        `CHK(rd[0], 1'b1)
        io(REG_STAT, 0);
        `CHK(rd[7:0], cop_status | 8'h80)
        repeat (60) @(posedge mclk);
        `CHK(bus.irq_line_two, 1'b1)
        ahb(0, REG_IRQ_STAT, 0);
        `CHK(rd[1], 1'b1)
        cop_pause <= 1;  // Stuck pause: ack must still come
        io(REG_STAT, 0);
        cop_pause <= 0;
        io(REG_STAT, 0);
        `CHK(rd[7:0], cop_status)
        `CHK(bus.irq_line_two, 1'b0)
        strap <= 0;  // Strap open: service request kept off line two
        svreq <= 1;
        repeat (3) @(posedge mclk);
        `CHK(bus.irq_line_two, 1'b0)
        strap <= 1;
        repeat (3) @(posedge mclk);
        `CHK(bus.irq_line_two, 1'b1)
        svreq <= 0;
        pwr <= 1;
        repeat (3) @(posedge mclk);
        `CHK(bus.irq_line_two, 1'b1)
        pwr <= 0;
        for (int i = 3; i >= 0; i--)
        begin
            io(REG_POP, 0);
            `CHK(rd[7:0], 8'((opnd + cmd) >> (8 * i)))
        end
        sh = 8'($random(seed)) | 8'h08;  // Bit three high: no reset yet
        io(REG_SHADOW, sh);
        ahb(0, REG_SHADOW, 0);
        `CHK(rd[7:0], sh)
        `CHK(hresp, 1'b0)
        ahb(1, REG_RESET, 0);
        for (n = 0; n < 40 && cop_rst_n !== 1'b0; n++) @(posedge mclk);
        `CHK(bus.io_wdata, sh & 8'hF7)
        for (n = 0; n < 100 && cop_rst_n === 1'b0; n++) @(posedge mclk);
        `CHK(n >= 8, 1'b1)
        `CHK(bus.io_wdata, sh)
        repeat (20) @(posedge mclk);
        ahb(0, REG_IRQ_STAT, 0);
        `CHK(rd[2], 1'b1)
        close_out();
    end
endmodule : tb
